/* rtl/status_reporting.sv */
/*
  Top of the status reporting tree: questionable, operation and standard
  event registers, status byte and service request mask.
  Assumes a command decoder presenting one-cycle access requests and
  asynchronous hardware status levels that need synchronising.
*/
`timescale 1ns/10ps
module status_reporting
  import status_pkg::*;
#(
  parameter int WIDTH = PART_W
) (
  input  wire logic clk_sys_i,
  input  wire logic reset_n_i,
  input  wire reg_req_t req_i,
  input  wire logic [WIDTH-1:0] ques_status_i,
  input  wire logic [WIDTH-1:0] oper_status_i,
  input  wire logic [BYTE_W-1:0] std_event_i,
  input  wire logic error_queue_nonempty_i,
  input  wire logic error_queue_push_i,
  input  wire logic output_message_waiting_i,
  input  wire logic serial_poll_i,
  output reg_rsp_t rsp_o,
  output logic [BYTE_W-1:0] poll_byte_o,
  output logic service_request_o
);

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (WIDTH != PART_W) begin : g_bad_width
    $error("status_reporting supports 16-bit parts only");
  end

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int SYNC_W = 2 * PART_W + BYTE_W + 4;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {ques_status_i, oper_status_i, std_event_i, error_queue_nonempty_i,
                  error_queue_push_i, output_message_waiting_i, serial_poll_i};
      sync2_q <= sync1_q;
    end
  end

  logic [PART_W-1:0] ques_cur;
  logic [PART_W-1:0] oper_cur;
  logic [BYTE_W-1:0] std_cur;
  logic errq_s;
  logic push_s;
  logic msg_s;
  logic poll_s;
  assign {ques_cur, oper_cur, std_cur, errq_s, push_s, msg_s, poll_s} = sync2_q;

  // ---------------------------------------------------------------
  // writable parts
  // ---------------------------------------------------------------
  logic [PART_W-1:0] rise_q [3];
  logic [PART_W-1:0] fall_q [3];
  logic [PART_W-1:0] enable_q [3];
  logic [BYTE_W-1:0] srq_mask_q;
  logic [PART_W-1:0] event_w [3];
  logic [2:0] summary_w;
  logic [2:0] clear_w;
  logic [PART_W-1:0] cur_w [3];
  logic [1:0] sel_idx;

  // selector 3 folds onto the standard event register for reads, writes and clears alike
  assign sel_idx = (req_i.reg_sel > SEL_STD_EVENT) ? SEL_STD_EVENT : req_i.reg_sel;

  // top bit forced low on every stored part
  for (genvar r = 0; r < 3; r++) begin : g_parts
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        rise_q[r] <= RISE_RESET;
        fall_q[r] <= FALL_RESET;
        enable_q[r] <= ENABLE_RESET;
      end else if (req_i.valid && req_i.write && sel_idx == 2'(r)) begin
        if (req_i.part_sel == PART_RISE) begin
          rise_q[r] <= req_i.wdata & PART_USED;
        end
        if (req_i.part_sel == PART_FALL) begin
          fall_q[r] <= req_i.wdata & PART_USED;
        end
        if (req_i.part_sel == PART_ENABLE) begin
          enable_q[r] <= req_i.wdata & PART_USED;
        end
      end
    end

    // a read of the event part clears it
    assign clear_w[r] = req_i.valid && !req_i.write && sel_idx == 2'(r)
                        && req_i.part_sel == PART_EVENT;

    status_register #(
      .WIDTH(PART_W)
    ) u_reg (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .current_i(cur_w[r]),
      .rise_i(rise_q[r]),
      .fall_i(fall_q[r]),
      .enable_i(enable_q[r]),
      .event_clear_i(clear_w[r]),
      .event_o(event_w[r]),
      .summary_o(summary_w[r])
    );
  end

  // current state straight from hardware; nothing writes it
  assign cur_w[0] = ques_cur & PART_USED;
  assign cur_w[1] = oper_cur & PART_USED;
  // standard event is 8 bits, upper part padded with zero
  assign cur_w[2] = {{(PART_W - BYTE_W){1'b0}}, std_cur};

  // ---------------------------------------------------------------
  // service request mask
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      srq_mask_q <= SRQ_MASK_RESET;
    end else if (req_i.valid && req_i.write && req_i.part_sel == PART_SRQ_MASK) begin
      srq_mask_q <= req_i.wdata[BYTE_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // status byte assembly
  // ---------------------------------------------------------------
  logic [BYTE_W-1:0] sb_low;
  logic [BYTE_W-1:0] sb_prev_q;
  logic [BYTE_W-1:0] status_byte;
  logic master_request_summary;
  logic standard_event_summary;

  // summaries feed the next level up
  assign standard_event_summary = summary_w[2];
  always_comb begin
    sb_low = '0; // bits 0 and 1 stay zero
    sb_low[SB_ERRQ] = errq_s;
    sb_low[SB_QUES] = summary_w[0];
    sb_low[SB_MSG] = msg_s;
    sb_low[SB_STD] = standard_event_summary;
    sb_low[SB_OPER] = summary_w[1];
  end

  // bit 6 ignored in the mask
  assign master_request_summary = |(sb_low & srq_mask_q & SRQ_MASK_USED);

  always_comb begin
    status_byte = sb_low;
    status_byte[SB_SUMMARY] = master_request_summary;
  end

  // ---------------------------------------------------------------
  // service request
  // ---------------------------------------------------------------
  // each error push re-arms a request even while the queue stays nonempty
  logic srq_hit;
  assign srq_hit = |(sb_low & ~sb_prev_q & srq_mask_q & SRQ_MASK_USED)
                   | (push_s & srq_mask_q[SB_ERRQ]);

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sb_prev_q <= '0;
      service_request_o <= 1'b0;
    end else begin
      sb_prev_q <= sb_low;
      // held until serial poll or summary drop; a new hit wins over poll
      if (srq_hit) begin
        service_request_o <= 1'b1;
      end else if (poll_s || !master_request_summary) begin
        service_request_o <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [PART_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    case (req_i.part_sel)
      PART_CURRENT: rd_mux = cur_w[sel_idx];
      PART_RISE: rd_mux = rise_q[sel_idx];
      PART_FALL: rd_mux = fall_q[sel_idx];
      PART_EVENT: rd_mux = event_w[sel_idx];
      PART_ENABLE: rd_mux = enable_q[sel_idx];
      PART_STATUS_BYTE: rd_mux = {8'h00, status_byte};
      PART_SRQ_MASK: rd_mux = {8'h00, srq_mask_q};
      default: rd_mux = '0;
    endcase
  end

  // one-cycle reply, top bit forced low
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rsp_o <= '0;
    end else begin
      rsp_o.valid <= req_i.valid && !req_i.write;
      rsp_o.rdata <= (req_i.valid && !req_i.write) ? (rd_mux & PART_USED) : 16'h0000;
    end
  end

  // status byte for serial poll, registered every cycle whether or not the poll is asserted
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      poll_byte_o <= '0;
    end else begin
      poll_byte_o <= status_byte;
    end
  end

endmodule

/* rtl/status_pkg.sv */
/*
  Shared constants and carrier types for the status reporting block.
  Assumes a single 100 MHz clock domain and a command decoder upstream.
*/
package status_pkg;

  // ---------------------------------------------------------------
  // widths and register selection
  // ---------------------------------------------------------------
  localparam int PART_W = 16;
  localparam int BYTE_W = 8;
  localparam int BIT_TOP = 15;

  // status register selector
  localparam logic [1:0] SEL_QUES = 2'h0;
  localparam logic [1:0] SEL_OPER = 2'h1;
  localparam logic [1:0] SEL_STD_EVENT = 2'h2;

  // part selector within a status register
  localparam logic [2:0] PART_CURRENT = 3'h0;
  localparam logic [2:0] PART_RISE = 3'h1;
  localparam logic [2:0] PART_FALL = 3'h2;
  localparam logic [2:0] PART_EVENT = 3'h3;
  localparam logic [2:0] PART_ENABLE = 3'h4;
  localparam logic [2:0] PART_STATUS_BYTE = 3'h5;
  localparam logic [2:0] PART_SRQ_MASK = 3'h6;

  // ---------------------------------------------------------------
  // status byte bit positions
  // ---------------------------------------------------------------
  localparam int SB_ERRQ = 2;
  localparam int SB_QUES = 3;
  localparam int SB_MSG = 4;
  localparam int SB_STD = 5;
  localparam int SB_SUMMARY = 6;
  localparam int SB_OPER = 7;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RISE_RESET = 16'h7FFF;
  localparam logic [15:0] FALL_RESET = 16'h0000;
  localparam logic [15:0] EVENT_RESET = 16'h0000;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [7:0] SRQ_MASK_RESET = 8'h00;
  // bits 0, 1 and 6 of the mask never take part in requests
  localparam logic [7:0] SRQ_MASK_USED = 8'hBC;
  localparam logic [15:0] PART_USED = 16'h7FFF;

  // register access request from the command decoder
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [1:0] reg_sel;
    logic [2:0] part_sel;
    logic [15:0] wdata;
  } reg_req_t;

  // reply towards the command decoder
  typedef struct packed {
    logic        valid;
    logic [15:0] rdata;
  } reg_rsp_t;

endpackage

/* rtl/status_register.sv */
/*
  One five-part status register with edge filters and summary.
  Assumes current-state inputs are already synchronous to clk_sys_i.
*/
`timescale 1ns/10ps
module status_register
  import status_pkg::*;
#(
  parameter int WIDTH = PART_W
) (
  input  wire logic clk_sys_i,
  input  wire logic reset_n_i,
  input  wire logic [WIDTH-1:0] current_i,
  input  wire logic [WIDTH-1:0] rise_i,
  input  wire logic [WIDTH-1:0] fall_i,
  input  wire logic [WIDTH-1:0] enable_i,
  input  wire logic event_clear_i,
  output logic [WIDTH-1:0] event_o,
  output logic summary_o
);

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (WIDTH != PART_W) begin : g_bad_width
    $error("status_register supports 16-bit parts only");
  end

  logic [WIDTH-1:0] prev_q;

  // previous current state for edge detection
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_q <= '0;
    end else begin
      prev_q <= current_i;
    end
  end

  // per-bit filter and latch; set wins over a read clear
  for (genvar b = 0; b < WIDTH; b++) begin : g_bit
    logic hit;
    assign hit = (current_i[b] & ~prev_q[b] & rise_i[b])
               | (~current_i[b] & prev_q[b] & fall_i[b]);
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        event_o[b] <= EVENT_RESET[b];
      end else if (hit && PART_USED[b]) begin
        event_o[b] <= 1'b1;
      end else if (event_clear_i) begin
        event_o[b] <= 1'b0;
      end
    end
  end

  // summary registered so the top output stays flop-driven
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      summary_o <= 1'b0;
    end else begin
      summary_o <= |(event_o & enable_i);
    end
  end

endmodule

/* bench/status_monitor.sv */
/*
  Port checker for status_reporting.
  Assumes it is bound into every status_reporting instance.
*/
`timescale 1ns/10ps
module status_monitor
  import status_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire reg_req_t req_i,
  input wire logic error_queue_nonempty_i,
  input wire logic output_message_waiting_i,
  input wire reg_rsp_t rsp_o,
  input wire logic [BYTE_W-1:0] poll_byte_o,
  input wire logic service_request_o
);
  // -------------------------------------------------
  // port relations
  // -------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // any status byte bit that may feed the summary
  wire logic others = |{poll_byte_o[7], poll_byte_o[5:2]};

  a_read_answer: assert property (rsp_o.valid == $past(req_i.valid && !req_i.write))
    else $error("read answer timing wrong");
  a_top_bit_zero: assert property (rsp_o.valid |-> !rsp_o.rdata[15])
    else $error("bit 15 of a part read as one");
  a_unused_bits: assert property (poll_byte_o[1:0] == 2'h0)
    else $error("unused status byte bits set");
  a_summary_cause: assert property (poll_byte_o[6] |-> others || $past(others))
    else $error("summary bit without a cause");
  a_request_cause: assert property ($rose(service_request_o) |-> ##[0:1] poll_byte_o[6])
    else $error("service request without summary");
  a_msg_set: assert property (output_message_waiting_i [*4] |-> poll_byte_o[4])
    else $error("message bit missing");
  a_msg_clear: assert property ((!output_message_waiting_i) [*4] |-> !poll_byte_o[4])
    else $error("message bit stuck");
  a_errq_set: assert property (error_queue_nonempty_i [*4] |-> poll_byte_o[2])
    else $error("error queue bit missing");
  // main scenarios reached
  c_read: cover property (rsp_o.valid);
  c_request: cover property ($rose(service_request_o));
  c_summary: cover property (poll_byte_o[6]);
endmodule
bind status_reporting status_monitor u_mon (
  .clk_sys_i(clk_sys_i),
  .reset_n_i(reset_n_i),
  .req_i(req_i),
  .error_queue_nonempty_i(error_queue_nonempty_i),
  .output_message_waiting_i(output_message_waiting_i),
  .rsp_o(rsp_o),
  .poll_byte_o(poll_byte_o),
  .service_request_o(service_request_o)
);

/* bench/remote_controller.sv */
/*
  Remote controller model: register commands and serial poll.
  Assumes the one-cycle request and answer timing of the block.
*/
`timescale 1ns/10ps
module remote_controller
  import status_pkg::*;
(
  input wire logic clk_sys_i,
  input wire reg_rsp_t rsp_i,
  output reg_req_t req_o,
  output logic serial_poll_o
);
  initial begin
    req_o = '0;
    serial_poll_o = 1'b0;
  end
  // one-cycle request; data inverted once released so stale values never match
  task automatic send(input logic w, input logic [1:0] s, input logic [2:0] p, input logic [15:0] d);
    @(posedge clk_sys_i);
    #1 req_o = '{1'b1, w, s, p, d};
    @(posedge clk_sys_i);
    #1 req_o = '{1'b0, w, s, p, ~d};
  endtask
  // answer is taken at the edge after the request edge
  task automatic rd(input logic [1:0] s, input logic [2:0] p, output logic [15:0] d);
    send(1'b0, s, p, 16'h0000);
    @(posedge clk_sys_i);
    d = rsp_i.valid ? rsp_i.rdata : 'x;
  endtask
  task automatic poll(input logic v);
    @(posedge clk_sys_i);
    #1 serial_poll_o = v;
  endtask
endmodule

/* bench/tb_top.sv */
/*
  Self-checking bench for status_reporting.
  Assumes the remote_controller model and the bound checker.
*/
`timescale 1ns/10ps
module tb_top;
  import status_pkg::*;
  logic clk_sys_i, reset_n_i, err_push, err_ne, msg, srq, spoll;
  logic [15:0] ques, oper;
  logic [7:0] std_ev, poll_byte;
  reg_req_t req;
  reg_rsp_t rsp;
  int err_total = 0;
  int cmp_count = 0;
  typedef struct packed {logic [1:0] s; logic [2:0] p; logic [15:0] w; logic [15:0] e;} row_t;
  row_t rows [8] = '{'{SEL_QUES, PART_RISE, 16'hFFFF, 16'h7FFF}, '{SEL_OPER, PART_FALL, 16'h1234, 16'h1234},
    '{SEL_STD_EVENT, PART_ENABLE, 16'h00A5, 16'h00A5}, '{SEL_OPER, PART_ENABLE, 16'h8001, 16'h0001},
    '{SEL_QUES, PART_CURRENT, 16'h5555, 16'h0000}, '{SEL_QUES, PART_EVENT, 16'h5555, 16'h0000},
    '{SEL_QUES, PART_SRQ_MASK, 16'h00BC, 16'h00BC}, '{2'h3, PART_FALL, 16'h0F0F, 16'h0F0F}};

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  status_reporting DUT (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .req_i(req), .ques_status_i(ques),
    .oper_status_i(oper), .std_event_i(std_ev), .error_queue_nonempty_i(err_ne), .error_queue_push_i(err_push),
    .output_message_waiting_i(msg), .serial_poll_i(spoll), .rsp_o(rsp), .poll_byte_o(poll_byte),
    .service_request_o(srq));
  remote_controller ctl (.clk_sys_i(clk_sys_i), .rsp_i(rsp), .req_o(req), .serial_poll_o(spoll));

  // -------------------------------------------------
  // helpers
  // -------------------------------------------------
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [1:0] s, input logic [2:0] p, input logic [15:0] e);
    logic [15:0] d;
    ctl.rd(s, p, d);
    chk(d, e);
  endtask
  task automatic wr(input logic [1:0] s, input logic [2:0] p, input logic [15:0] w);
    ctl.send(1'b1, s, p, w);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // reset held two cycles, released just after an edge
  task automatic do_reset();
    reset_n_i = 1'b0;
    idle(2);
    #1 reset_n_i = 1'b1;
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // run is under two hundred cycles; this cuts a hang short
  initial begin
    #100us;
    err_total++;
    $display("ERROR t=%0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    {ques, oper, std_ev, err_ne, err_push, msg} = '0;
    do_reset();
    foreach (rows[i]) begin
      wr(rows[i].s, rows[i].p, rows[i].w);
      rc(rows[i].s, rows[i].p, rows[i].e);
      rc(rows[i].s, rows[i].p, rows[i].e);
    end
    $display("test access table done");
    // mid-run reset must undo every value the table wrote
    do_reset();
    for (int r = 0; r < 3; r++) begin
      rc(r[1:0], PART_RISE, 16'h7FFF);
      rc(r[1:0], PART_FALL, 16'h0000);
      rc(r[1:0], PART_ENABLE, 16'h0000);
    end
    rc(SEL_QUES, PART_SRQ_MASK, 16'h0000);
    $display("test reset values done");
    wr(SEL_QUES, PART_RISE, 16'h0001);
    wr(SEL_QUES, PART_FALL, 16'h0002);
    wr(SEL_QUES, PART_ENABLE, 16'h0002);
    wr(SEL_QUES, PART_SRQ_MASK, 16'h0008);
    idle(1);
    #1 ques = 16'h0003;
    idle(8);
    rc(SEL_QUES, PART_CURRENT, 16'h0003);
    rc(SEL_QUES, PART_EVENT, 16'h0001);
    chk({8'h00, poll_byte}, 16'h0000);
    #1 ques = 16'h0000;
    idle(8);
    chk({8'h00, poll_byte}, 16'h0048);
    chk({15'h0000, srq}, 16'h0001);
    rc(SEL_QUES, PART_EVENT, 16'h0002);
    rc(SEL_QUES, PART_EVENT, 16'h0000);
    idle(4);
    chk({8'h00, poll_byte}, 16'h0000);
    $display("test edge filters done");
    wr(SEL_QUES, PART_SRQ_MASK, 16'h0044);
    wr(SEL_OPER, PART_ENABLE, 16'h0008);
    wr(SEL_STD_EVENT, PART_ENABLE, 16'h0001);
    idle(1);
    #1 {oper, std_ev, msg} = {16'h0008, 8'h01, 1'b1};
    idle(8);
    chk({8'h00, poll_byte}, 16'h00B0);
    chk({15'h0000, srq}, 16'h0000);
    #1 {err_ne, err_push} = 2'h3;
    idle(1);
    #1 err_push = 1'b0;
    idle(8);
    chk({8'h00, poll_byte}, 16'h00F4);
    chk({15'h0000, srq}, 16'h0001);
    rc(SEL_QUES, PART_STATUS_BYTE, 16'h00F4);
    ctl.poll(1'b1);
    idle(6);
    chk({15'h0000, srq}, 16'h0000);
    ctl.poll(1'b0);
    // second entry while the queue bit is already high
    #1 err_push = 1'b1;
    idle(1);
    #1 err_push = 1'b0;
    idle(8);
    chk({15'h0000, srq}, 16'h0001);
    $display("test status byte done");
    finish_test();
  end
endmodule
